/* inc/eec_pkg.sv */
// Package for the enclave entry checker: register map, field layout, constants.
// Assumes a single AHB-Lite slave port with 32-bit data.
package eec_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] EEC_CMD_OFS     = 8'h00;
    localparam logic [7:0] EEC_STATUS_OFS  = 8'h04;
    localparam logic [7:0] EEC_TCSADR_OFS  = 8'h08;
    localparam logic [7:0] EEC_AEP_OFS     = 8'h0C;
    localparam logic [7:0] EEC_TCSFLG_OFS  = 8'h10;
    localparam logic [7:0] EEC_ENTRY_OFFSET_FIELD_OFS  = 8'h14;
    localparam logic [7:0] EEC_BASE_OFS    = 8'h18;
    localparam logic [7:0] EEC_FSOFS_OFS   = 8'h1C;
    localparam logic [7:0] EEC_GSOFS_OFS   = 8'h20;
    localparam logic [7:0] EEC_FSLIM_OFS   = 8'h24;
    localparam logic [7:0] EEC_GSLIM_OFS   = 8'h28;
    localparam logic [7:0] EEC_DSLIM_OFS   = 8'h2C;
    localparam logic [7:0] EEC_CSLIM_OFS   = 8'h30;
    localparam logic [7:0] EEC_CTRL_OFS    = 8'h34;
    localparam logic [7:0] EEC_FEATURE_REQUEST_MASK_OFS    = 8'h38;
    localparam logic [7:0] EEC_XCR_OFS     = 8'h3C;
    localparam logic [7:0] EEC_RIP_OFS     = 8'h40;
    localparam logic [7:0] EEC_SAVED_OFS   = 8'h44;
    localparam logic [7:0] EEC_PERF_OFS    = 8'h48;
    localparam logic [7:0] EEC_SEGB_OFS    = 8'h4C;
    localparam logic [7:0] EEC_SPFP_OFS    = 8'h50;
    // ************************************************************
    // Command and control fields
    // ************************************************************
    localparam logic [7:0]  EEC_LEAF_ENTER  = 8'h02;
    localparam int          EEC_CMD_GO_BIT  = 8;
    localparam int          EEC_C_OSFXSR    = 0;
    localparam int          EEC_C_OSXSAVE   = 1;
    localparam int          EEC_C_XSAVEAV   = 2;
    localparam int          EEC_C_ENCLAVE_WIDE_MODE_ATTR    = 3;
    localparam int          EEC_C_ATTR64    = 4;
    localparam int          EEC_C_OPTOUT    = 5;
    localparam int          EEC_C_TCSVALID  = 6;
    localparam int          EEC_C_TCSLOCK   = 7;
    localparam int          EEC_C_SECSBUSY  = 8;
    localparam int          EEC_C_INITED    = 9;
    localparam int          EEC_C_SHARECONF = 10;
    localparam int          EEC_C_DRAINED   = 11;
    localparam int          EEC_C_TF        = 12;
    localparam int          EEC_C_CURRENT_SAVE_FRAME_INDEX_LSB  = 16;
    localparam logic [31:0] EEC_FEATURE_REQUEST_MASK_LEGACY = 32'h0000_0003;
    localparam logic [11:0] EEC_PAGE_MASK   = 12'hFFF;
    // Global performance status bits
    localparam int          EEC_PS_DEMOTE   = 60;
    localparam int          EEC_PS_SUPPR    = 63;
    // Status fields
    localparam int          EEC_S_BUSY      = 0;
    localparam int          EEC_S_DONE      = 1;
    localparam int          EEC_S_FAULT     = 2;
    localparam int          EEC_S_ENCL      = 3;
    localparam int          EEC_S_CAUSE_LSB = 8;
    typedef enum logic [3:0] {
        EEC_IDLE  = 4'b0001,
        EEC_DRAIN = 4'b0010,
        EEC_CHECK = 4'b0100,
        EEC_COMMIT = 4'b1000
    } eec_state_t;
endpackage

/* rtl/eec_top.sv */
// Enclave entry checker: checks entry preconditions, then commits entry state.
// Assumes an AHB-Lite master with single word transfers and synchronous inputs.
`timescale 1ns/1ns
module eec_top
    import eec_pkg::*;
#(
    parameter int AW = 32
) (
    input  wire logic          CLK_I,
    input  wire logic          RST_I,
    input  wire logic          CE_I,
    input  wire logic          HSEL_I,
    input  wire logic [31:0]   HADDR_I,
    input  wire logic [1:0]    HTRANS_I,
    input  wire logic          HWRITE_I,
    input  wire logic [2:0]    HSIZE_I,
    input  wire logic [31:0]   HWDATA_I,
    input  wire logic          HREADY_I,
    output logic      [31:0]   HRDATA_O,
    output logic               HREADYOUT_O,
    output logic               HRESP_O,
    input  wire logic [31:0]   SEG_BASE_OR_I,
    input  wire logic [31:0]   STACK_PTR_I,
    input  wire logic [31:0]   FRAME_PTR_I,
    input  wire logic          FLAG_POP_SET_I,
    output logic               ENCLAVE_MODE_O,
    output logic               TRAP_FLAG_O,
    output logic               SINGLE_STEP_PEND_O,
    output logic               CODE_BP_OUT_SUPPR_O,
    output logic               BP_IN_SUPPR_O,
    output logic               PERF_SUPPR_O,
    output logic               PRECISE_EVENT_SAMPLING_SUPPR_O,
    output logic               DEMOTE_OTHERS_O,
    output logic               FAULT_O
);
    initial begin
        if (AW != 32) $error("eec_top: only AW=32 supported");
    end

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic        take;
    logic        rd_take;
    assign take        = HSEL_I && HREADY_I && HTRANS_I[1];
    assign rd_take     = take && !HWRITE_I;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else if (CE_I) begin
            wr_pend_q <= take && HWRITE_I;
            if (take) begin
                addr_q <= HADDR_I[7:0];
            end
        end
    end

    logic wr;
    assign wr = wr_pend_q && CE_I;

    // ************************************************************
    // Software-loaded operands
    // ************************************************************
    logic [31:0] tcs_adr_q, aep_q, tcs_flg_q, entry_offset_field_q, base_q, fs_ofs_q, gs_ofs_q;
    logic [31:0] fs_lim_q, gs_lim_q, ds_lim_q, cs_lim_q, ctrl_q, feature_request_mask_q, xcr_q;
    logic        go;
    assign go = wr && (addr_q == EEC_CMD_OFS) && HWDATA_I[EEC_CMD_GO_BIT]
                && (HWDATA_I[7:0] == EEC_LEAF_ENTER);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tcs_adr_q <= 32'h0;
            aep_q     <= 32'h0;
            tcs_flg_q <= 32'h0;
            entry_offset_field_q  <= 32'h0;
            base_q    <= 32'h0;
            fs_ofs_q  <= 32'h0;
            gs_ofs_q  <= 32'h0;
            fs_lim_q  <= 32'h0;
            gs_lim_q  <= 32'h0;
            ds_lim_q  <= 32'h0;
            cs_lim_q  <= 32'h0;
            ctrl_q    <= 32'h0;
            feature_request_mask_q    <= 32'h0;
            xcr_q     <= 32'h0;
        end else if (wr) begin
            case (addr_q)
                EEC_TCSADR_OFS: tcs_adr_q <= HWDATA_I;
                EEC_AEP_OFS:    aep_q     <= HWDATA_I;
                EEC_TCSFLG_OFS: tcs_flg_q <= HWDATA_I;
                EEC_ENTRY_OFFSET_FIELD_OFS: entry_offset_field_q  <= HWDATA_I;
                EEC_BASE_OFS:   base_q    <= HWDATA_I;
                EEC_FSOFS_OFS:  fs_ofs_q  <= HWDATA_I;
                EEC_GSOFS_OFS:  gs_ofs_q  <= HWDATA_I;
                EEC_FSLIM_OFS:  fs_lim_q  <= HWDATA_I;
                EEC_GSLIM_OFS:  gs_lim_q  <= HWDATA_I;
                EEC_DSLIM_OFS:  ds_lim_q  <= HWDATA_I;
                EEC_CSLIM_OFS:  cs_lim_q  <= HWDATA_I;
                EEC_CTRL_OFS:   ctrl_q    <= HWDATA_I;
                EEC_FEATURE_REQUEST_MASK_OFS:   feature_request_mask_q    <= HWDATA_I;
                EEC_XCR_OFS:    xcr_q     <= HWDATA_I;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Precondition checks, each one bit of the fault cause
    // ************************************************************
    logic        enclave_wide_mode_attr;
    logic [31:0] target, fs_base, gs_base, fs_top, gs_top;
    logic [15:0] cause;
    assign enclave_wide_mode_attr  = ctrl_q[EEC_C_ENCLAVE_WIDE_MODE_ATTR];
    assign target  = entry_offset_field_q + base_q;
    assign fs_base = fs_ofs_q + base_q;
    assign gs_base = gs_ofs_q + base_q;
    assign fs_top  = fs_base + fs_lim_q;
    assign gs_top  = gs_base + gs_lim_q;

    // In 64-bit mode the 32-bit datapath has no upper bits, so canonical always holds
    always_comb begin
        cause     = 16'h0000;
        cause[0]  = !enclave_wide_mode_attr && (target > cs_lim_q);
        cause[1]  = (tcs_adr_q[11:0] & EEC_PAGE_MASK) != 12'h000;
        cause[2]  = !ctrl_q[EEC_C_TCSVALID] || ctrl_q[EEC_C_TCSLOCK];
        cause[3]  = ctrl_q[EEC_C_SECSBUSY] || ctrl_q[EEC_C_SHARECONF];
        cause[4]  = tcs_flg_q[31:1] != 31'h0;
        cause[5]  = enclave_wide_mode_attr != ctrl_q[EEC_C_ATTR64];
        cause[6]  = SEG_BASE_OR_I != 32'h0;
        cause[7]  = !enclave_wide_mode_attr && (fs_top < fs_base ? ds_lim_q != 32'hFFFF_FFFF
                                                 : fs_top > ds_lim_q);
        cause[8]  = !enclave_wide_mode_attr && (gs_top < gs_base ? ds_lim_q != 32'hFFFF_FFFF
                                                 : gs_top > ds_lim_q);
        cause[9]  = !ctrl_q[EEC_C_OSFXSR];
        cause[10] = ctrl_q[EEC_C_XSAVEAV] && !ctrl_q[EEC_C_OSXSAVE]
                    && (feature_request_mask_q != EEC_FEATURE_REQUEST_MASK_LEGACY);
        cause[11] = ctrl_q[EEC_C_OSXSAVE] && ((feature_request_mask_q & ~xcr_q) != 32'h0);
        cause[12] = !ctrl_q[EEC_C_INITED];
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    eec_state_t  st_q;
    logic        done_q, fault_q, encl_q;
    logic [15:0] cause_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q    <= EEC_IDLE;
            done_q  <= 1'b0;
            fault_q <= 1'b0;
            cause_q <= 16'h0000;
        end else if (CE_I) begin
            case (st_q)
                EEC_IDLE: if (go) begin
                    st_q   <= EEC_DRAIN;
                    done_q <= 1'b0;
                end
                EEC_DRAIN: if (ctrl_q[EEC_C_DRAINED]) begin
                    st_q <= EEC_CHECK;
                end
                EEC_CHECK: begin
                    cause_q <= cause;
                    fault_q <= cause != 16'h0000;
                    st_q    <= (cause != 16'h0000) ? EEC_IDLE : EEC_COMMIT;
                    done_q  <= cause != 16'h0000;
                end
                EEC_COMMIT: begin
                    st_q   <= EEC_IDLE;
                    done_q <= 1'b1;
                end
                default: st_q <= EEC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Commit of architectural state
    // ************************************************************
    logic [31:0] rip_q, tcs_aep_q, saved_xcr_q, new_fs_q, new_gs_q, fs_lim_new_q, sv_sp_q, sv_fp_q;
    logic        sv_tf_q, tf_q, step_q, optout_q;
    logic        commit;
    assign commit = CE_I && (st_q == EEC_COMMIT);
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rip_q        <= 32'h0;
            tcs_aep_q    <= 32'h0;
            saved_xcr_q  <= 32'h0;
            new_fs_q     <= 32'h0;
            new_gs_q     <= 32'h0;
            fs_lim_new_q <= 32'h0;
            sv_sp_q      <= 32'h0;
            sv_fp_q      <= 32'h0;
            encl_q       <= 1'b0;
            optout_q     <= 1'b0;
            sv_tf_q      <= 1'b0;
            step_q       <= 1'b0;
        end else if (commit) begin
            rip_q        <= target;
            sv_sp_q      <= STACK_PTR_I;
            sv_fp_q      <= FRAME_PTR_I;
            tcs_aep_q    <= aep_q;
            new_fs_q     <= fs_base;
            new_gs_q     <= gs_base;
            fs_lim_new_q <= enclave_wide_mode_attr ? 32'h0 : fs_lim_q;
            if (ctrl_q[EEC_C_OSXSAVE]) begin
                saved_xcr_q <= xcr_q;
            end
            encl_q       <= 1'b1;
            optout_q     <= ctrl_q[EEC_C_OPTOUT];
            sv_tf_q      <= ctrl_q[EEC_C_TF];
            step_q       <= !ctrl_q[EEC_C_OPTOUT];
        end else if (CE_I) begin
            step_q <= 1'b0;
        end
    end

    // Effective trap flag: host value on opt-in entry, cleared on opt-out inside
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tf_q <= 1'b0;
        end else if (CE_I) begin
            if (commit) begin
                tf_q <= ctrl_q[EEC_C_OPTOUT] ? 1'b0 : ctrl_q[EEC_C_TF];
            end else if (encl_q && optout_q && FLAG_POP_SET_I) begin
                tf_q <= 1'b0;
            end else if (encl_q && FLAG_POP_SET_I) begin
                tf_q <= 1'b1;
            end
        end
    end

    logic [31:0] xcr_live;
    assign xcr_live = (encl_q && ctrl_q[EEC_C_OSXSAVE]) ? feature_request_mask_q : xcr_q;

    assign ENCLAVE_MODE_O      = encl_q;
    assign TRAP_FLAG_O         = tf_q;
    assign SINGLE_STEP_PEND_O  = step_q;
    assign CODE_BP_OUT_SUPPR_O = encl_q;
    assign BP_IN_SUPPR_O       = encl_q && optout_q;
    assign PERF_SUPPR_O        = encl_q && optout_q;
    assign PRECISE_EVENT_SAMPLING_SUPPR_O        = encl_q && optout_q;
    assign DEMOTE_OTHERS_O     = encl_q && optout_q;
    assign FAULT_O             = fault_q;

    // Upper half of global performance status
    logic [31:0] perf_hi;
    always_comb begin
        perf_hi = 32'h0;
        perf_hi[EEC_PS_DEMOTE - 32] = encl_q && optout_q;
        perf_hi[EEC_PS_SUPPR - 32]  = encl_q && optout_q;
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [31:0] rd_d, rd_q;
    always_comb begin
        case (HADDR_I[7:0])
            EEC_STATUS_OFS: rd_d = {16'h0, cause_q[7:0], 4'h0, encl_q, fault_q, done_q,
                                    st_q != EEC_IDLE};
            EEC_TCSADR_OFS: rd_d = tcs_adr_q;
            EEC_AEP_OFS:    rd_d = tcs_aep_q;
            EEC_CTRL_OFS:   rd_d = ctrl_q;
            EEC_FEATURE_REQUEST_MASK_OFS:   rd_d = feature_request_mask_q;
            EEC_XCR_OFS:    rd_d = xcr_live;
            EEC_RIP_OFS:    rd_d = rip_q;
            EEC_SAVED_OFS:  rd_d = saved_xcr_q;
            EEC_PERF_OFS:   rd_d = perf_hi;
            EEC_SEGB_OFS:   rd_d = new_fs_q ^ new_gs_q ^ fs_lim_new_q;
            EEC_SPFP_OFS:   rd_d = sv_sp_q ^ sv_fp_q ^ {31'h0, sv_tf_q};
            EEC_CMD_OFS:    rd_d = {16'h0, ctrl_q[31:16]};
            default:        rd_d = 32'h0;
        endcase
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_q <= 32'h0;
        end else if (CE_I && rd_take) begin
            rd_q <= rd_d;
        end
    end
    assign HRDATA_O = rd_q;
endmodule

/* bench/eec_monitor.sv */
// Port-level checker for the enclave entry checker.
// Assumes it is bound onto eec_top and sees only its ports.
`timescale 1ns/1ns
module eec_monitor (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic ENCLAVE_MODE_O,
    input wire logic TRAP_FLAG_O,
    input wire logic SINGLE_STEP_PEND_O,
    input wire logic CODE_BP_OUT_SUPPR_O,
    input wire logic BP_IN_SUPPR_O,
    input wire logic PERF_SUPPR_O,
    input wire logic PRECISE_EVENT_SAMPLING_SUPPR_O,
    input wire logic DEMOTE_OTHERS_O,
    input wire logic FAULT_O
);
    // ************************************************************
    // Entry behaviour
    // ************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_entered;
        !ENCLAVE_MODE_O ##1 ENCLAVE_MODE_O;
    endsequence
    sequence s_opt_in_entry;
        s_entered ##0 !BP_IN_SUPPR_O;
    endsequence
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus not ready or not okay");
    a_mode_sticks: assert property (ENCLAVE_MODE_O |=> ENCLAVE_MODE_O)
        else $error("enclave mode dropped");
    a_code_bp: assert property (s_entered |-> CODE_BP_OUT_SUPPR_O)
        else $error("outside code breakpoints not suppressed");
    a_opt_out_set: assert property ($rose(BP_IN_SUPPR_O) |-> PERF_SUPPR_O && PRECISE_EVENT_SAMPLING_SUPPR_O && DEMOTE_OTHERS_O)
        else $error("opt-out suppression incomplete");
    a_trap_held: assert property (BP_IN_SUPPR_O |-> !TRAP_FLAG_O)
        else $error("trap flag set in opt-out enclave");
    a_step_pend: assert property (s_opt_in_entry |-> ##[0:1] SINGLE_STEP_PEND_O)
        else $error("single step not pended");
    a_step_once: assert property (SINGLE_STEP_PEND_O |=> !SINGLE_STEP_PEND_O)
        else $error("single step pend longer than one cycle");
    a_step_opt_in: assert property (SINGLE_STEP_PEND_O |-> ENCLAVE_MODE_O && !BP_IN_SUPPR_O)
        else $error("single step pended outside opt-in entry");
    a_fault_clean: assert property (FAULT_O |-> !ENCLAVE_MODE_O && !CODE_BP_OUT_SUPPR_O)
        else $error("faulting entry changed state");
    a_suppr_inside: assert property ((PERF_SUPPR_O || DEMOTE_OTHERS_O || BP_IN_SUPPR_O) |-> ENCLAVE_MODE_O)
        else $error("suppression outside enclave");
endmodule

/* bench/eec_core_model.sv */
// Model of the issuing core: pointers, segment bases and flag pops.
// Assumes the testbench requests segment bases and flag-pop pulses.
`timescale 1ns/1ns
module eec_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        pop_i,
    input  wire logic [31:0] seg_i,
    output logic      [31:0] seg_base_o,
    output logic      [31:0] stack_o,
    output logic      [31:0] frame_o,
    output logic             pop_o
);
    // Pointers keep moving so a stale sample is visible
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stack_o <= 32'h0000_8000;
            frame_o <= 32'h0000_9000;
            pop_o <= 1'b0;
            seg_base_o <= 32'h0;
        end else begin
            stack_o <= stack_o - 32'h4;
            frame_o <= ~stack_o;
            pop_o <= pop_i;
            seg_base_o <= seg_i;
        end
    end
endmodule

/* bench/testbench.sv */
// Self-checking bench: AHB-Lite master, core model, reference model of entry.
// Assumes eec_top with a zero-wait slave; one entry per reset.
`timescale 1ns/1ns
module testbench;
    import eec_pkg::*;
    localparam logic [31:0] BASE_V [0:15] = '{32'h0, 32'h0, 32'h3000, 32'h0, 32'h0, 32'h100, 32'h1000_0000,
        32'h1000, 32'h2000, 32'hFFF, 32'hFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0A41, 32'h3, 32'h3};
    logic        clk, rst, hsel, hwrite, pop_req, flag_pop, encl, trap, step, cbp, bpin, perf, precise_event_sampling, demote, fault;
    logic        hready, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, seg_req, seg_base, sp, fp, rd;
    logic [31:0] v [0:15];
    int          mismatches, tests_run, k;
    eec_core_model u_core (.clk_i(clk), .rst_i(rst), .pop_i(pop_req), .seg_i(seg_req), .seg_base_o(seg_base),
        .stack_o(sp), .frame_o(fp), .pop_o(flag_pop));
    eec_top dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .SEG_BASE_OR_I(seg_base), .STACK_PTR_I(sp), .FRAME_PTR_I(fp),
        .FLAG_POP_SET_I(flag_pop), .ENCLAVE_MODE_O(encl), .TRAP_FLAG_O(trap), .SINGLE_STEP_PEND_O(step),
        .CODE_BP_OUT_SUPPR_O(cbp), .BP_IN_SUPPR_O(bpin), .PERF_SUPPR_O(perf), .PRECISE_EVENT_SAMPLING_SUPPR_O(precise_event_sampling),
        .DEMOTE_OTHERS_O(demote), .FAULT_O(fault));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 40) begin
                mismatches++;
                complete_run();
            end
            @(posedge clk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    function automatic bit exp_fault();
        logic [31:0] c;
        logic [31:0] fb;
        logic [31:0] fl;
        logic [31:0] gb;
        logic [31:0] gl;
        bit          f;
        c = v[13];
        fb = v[7] + v[6];
        fl = fb + v[9];
        gb = v[8] + v[6];
        gl = gb + v[10];
        f = v[2][11:0] != 0 || !c[6] || c[7] || c[8] || !c[9] || c[10] || v[4][31:1] != 0;
        f |= c[3] != c[4] || seg_req != 0 || !c[0] || (c[2] && !c[1] && v[14] != 32'h3);
        f |= c[1] && (v[14] & ~v[15]) != 0;
        if (!c[3]) begin
            f |= (fl < fb) ? v[11] != 32'hFFFF_FFFF : fl > v[11];
            f |= (gl < gb) ? v[11] != 32'hFFFF_FFFF : gl > v[11];
            f |= v[5] + v[6] > v[12];
        end
        return f;
    endfunction
    // ************************************************************
    // One entry attempt per case
    // ************************************************************
    task automatic entry(input int t);
        logic [31:0] c;
        bit          f;
        bit          o;
        int          i;
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        v = BASE_V;
        v[3] = $urandom;
        v[4] = $urandom & 32'h1;
        seg_req = 32'h0;
        case (t)
            1: v[13] = 32'h1A61;
            2: v[2] = 32'h3040;
            3: v[13] = 32'h0A01;
            4: v[13] = 32'h0AC1;
            5: v[13] = 32'h0B41;
            6: v[13] = 32'h0E41;
            7: v[13] = 32'h0841;
            8: v[4] = 32'h2;
            9: v[13] = 32'h0A51;
            10: seg_req = 32'h10;
            11: v[11] = 32'h1000_1FFF;
            12: v[13] = 32'h0A40;
            13: {v[13], v[14]} = {32'h0A45, 32'h7};
            14: {v[13], v[14]} = {32'h0A43, 32'h7};
            15: {v[13], v[15]} = {32'h0A63, 32'h7};
            16: v[12] = 32'h1000_00FF;
            17: {v[13], v[12]} = {32'h0A59, 32'h0};
            default: {v[13], v[5], v[12]} = {v[13] ^ (32'h1 << ($urandom % 11)), $urandom % 32'h200, 32'h1000_0100};
        endcase
        v[13][31:16] = 16'($urandom);
        c = v[13];
        for (i = 2; i < 16; i++) bus(1'b1, 8'(i * 4), v[i]);
        bus(1'b1, EEC_CMD_OFS, 32'h0000_0103);
        repeat (6) @(posedge clk);
        bus(1'b0, EEC_STATUS_OFS, 32'h0);
        check(rd & 32'hE, 32'h0);
        bus(1'b1, EEC_CTRL_OFS, c & ~32'h800);
        bus(1'b1, EEC_CMD_OFS, 32'h0000_0102);
        repeat (6) @(posedge clk);
        check({30'h0, encl, fault}, 32'h0);
        bus(1'b1, EEC_CTRL_OFS, c);
        for (i = 0; i < 40 && rd[EEC_S_DONE] !== 1'b1; i++) bus(1'b0, EEC_STATUS_OFS, 32'h0);
        if (i == 40) begin
            mismatches++;
            complete_run();
        end
        f = exp_fault();
        o = c[5] & ~f;
        check({29'h0, rd[3:1]}, {29'h0, ~f, f, 1'b1});
        check({29'h0, encl, fault, cbp}, {29'h0, ~f, f, ~f});
        bus(1'b0, EEC_RIP_OFS, 32'h0);
        check(rd, f ? 32'h0 : v[5] + v[6]);
        check({28'h0, bpin, perf, precise_event_sampling, demote}, {28'h0, {4{o}}});
        bus(1'b0, EEC_PERF_OFS, 32'h0);
        check(rd, o ? 32'h9000_0000 : 32'h0);
        bus(1'b0, EEC_AEP_OFS, 32'h0);
        check(rd, f ? 32'h0 : v[3]);
        bus(1'b0, EEC_CMD_OFS, 32'h0);
        check(rd, {16'h0, c[31:16]});
        bus(1'b0, EEC_SEGB_OFS, 32'h0);
        check(rd, f ? 32'h0 : (v[7] + v[6]) ^ (v[8] + v[6]) ^ (c[3] ? 32'h0 : v[9]));
        bus(1'b0, 8'hFC, 32'h0);
        check(rd, 32'h0);
        if (c[1] && !f) begin
            bus(1'b0, EEC_XCR_OFS, 32'h0);
            check(rd, v[14]);
            bus(1'b0, EEC_SAVED_OFS, 32'h0);
            check(rd, v[15]);
        end
        pop_req <= 1'b1;
        @(posedge clk);
        pop_req <= 1'b0;
        repeat (3) @(posedge clk);
        if (o) check({31'h0, trap}, 32'h0);
        $display("test %0d done", t);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst, hsel, hwrite, pop_req, htrans, haddr, hwdata, seg_req} = '0;
        mismatches = 0;
        tests_run = 0;
        void'($urandom(44));
        for (k = 0; k < 24; k++) entry(k);
        complete_run();
    end
endmodule
bind eec_top eec_monitor u_mon (.CLK_I(CLK_I), .RST_I(RST_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .ENCLAVE_MODE_O(ENCLAVE_MODE_O), .TRAP_FLAG_O(TRAP_FLAG_O), .SINGLE_STEP_PEND_O(SINGLE_STEP_PEND_O),
    .CODE_BP_OUT_SUPPR_O(CODE_BP_OUT_SUPPR_O), .BP_IN_SUPPR_O(BP_IN_SUPPR_O), .PERF_SUPPR_O(PERF_SUPPR_O),
    .PRECISE_EVENT_SAMPLING_SUPPR_O(PRECISE_EVENT_SAMPLING_SUPPR_O), .DEMOTE_OTHERS_O(DEMOTE_OTHERS_O), .FAULT_O(FAULT_O));
